// *** shared/uamc_cfg.svh ***
/*
 * Constants of the alternate-mode controller: register byte offsets,
 * field positions, reset values and response codes.
 * Assumes it is included by bare name once per compilation unit.
 */
`ifndef UAMC_CFG_SVH
`define UAMC_CFG_SVH

// ==========================================================
// Register byte offsets (one aligned 32-bit word each)
`define UAMC_OFS_CTRL 8'h00
`define UAMC_OFS_MASK 8'h04
`define UAMC_OFS_MEAS 8'h08
`define UAMC_OFS_STAT 8'h0C
`define UAMC_OFS_HSET 8'h10

// ==========================================================
// Control register fields
`define UAMC_CTRL_KEEP 0
`define UAMC_CTRL_TXEN 1
`define UAMC_CTRL_RXEN 2
`define UAMC_CTRL_ACC 3
`define UAMC_CTRL_LEFT 4
`define UAMC_CTRL_RIGHT 5
`define UAMC_CTRL_XCVR 6
`define UAMC_CTRL_REGLV 8
`define UAMC_CTRL_W 10
`define UAMC_CTRL_RST 10'h040

// ==========================================================
// Measurement register fields
`define UAMC_MEAS_START 0
`define UAMC_MEAS_NOTIFY 1
`define UAMC_MEAS_CODE 8

// ==========================================================
// Miscellaneous encodings
`define UAMC_XCVR_LS 2'h2
`define UAMC_RESP_OK 2'h0
`define UAMC_RESP_ERR 2'h2
`define UAMC_RXCMD_ALT 7
`define UAMC_RXCMD_ID 6

`endif

// *** shared/uamc_pkg.sv ***
/*
 * Types shared by the alternate-mode controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uamc_pkg;

    // ==========================================================
    // Interface mode, one-hot
    typedef enum logic [4:0]
    {
        UAMC_SYNC = 5'h01,
        UAMC_ENTER = 5'h02,
        UAMC_ACC = 5'h04,
        UAMC_HSET = 5'h08,
        UAMC_EXIT = 5'h10
    } uamc_mode_e;

endpackage

// *** hdl/uamc_alt_mode.sv ***
/*
 * Alternate-mode controller of a ULPI transceiver: accessory (UART and
 * audio) mode, headset mode, ID measurement handshake, AXI4-Lite registers.
 * Assumes every input is synchronous to core_clk and that the analog
 * comparators and the converter are outside this block.
 */
`timescale 1ns/1ps
`include "uamc_cfg.svh"
module uamc_alt_mode
    import uamc_pkg::*;
#(
    parameter int IRQ_W = 5,
    parameter int CODE_W = 3,
    parameter int BUSVLD_IRQ = 1
)
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hardResetPinN,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // ULPI link side
    input wire logic stp,
    output logic dir,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic [7:0] dataOe,
    output logic clkRun,
    input wire logic [1:0] lineState,
    output logic rxcmdStrobe,
    output logic [7:0] rxcmdByte,
    // Analog front end
    input wire logic [IRQ_W-1:0] irqSrc,
    input wire logic sessionValidComparator,
    input wire logic busPowerValidComparator,
    input wire logic idGroundedComparator,
    input wire logic idFloatingState,
    input wire logic dpIn,
    output logic dmOut,
    output logic dmOe,
    output logic uartPullupEn,
    output logic uartRegulatorSel,
    output logic [1:0] regulatorLevel,
    output logic lowSpeedEdges,
    output logic leftAudioSwitch,
    output logic rightAudioSwitch,
    output logic idGroundDrive,
    output logic idWeakPullupEnable,
    output logic idStrongPullupEnable,
    // Resistance converter
    output logic measStartPulse,
    input wire logic measDone,
    input wire logic [CODE_W-1:0] measCode
);

    // ==========================================================
    // State
    uamc_mode_e mode_q, mode_d;
    logic [`UAMC_CTRL_W-1:0] ctrl_q; // Control register
    logic [IRQ_W-1:0] mask_q; // Interrupt source mask
    logic [IRQ_W-1:0] snap_q; // Source levels sampled before DIR
    logic hsetTarget_q; // Entry heads for headset mode
    logic measStart_q, measNotify_q;
    logic [CODE_W-1:0] measCode_q;
    logic altPend_q; // Completion RXCMD still owed
    logic idFellAlt_q; // ID fall seen outside synchronous mode
    logic idPrev_q;
    logic awr_q, wr_q, bv_q, arr_q, rv_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] dOut_q, dOe_q, rxByte_q;
    logic dir_q, clk_q, rxStb_q, dm_q, dmOe_q, pu_q, regSel_q, ls_q;
    logic [1:0] regLv_q;
    logic left_q, right_q, gnd_q, wpu_q, spu_q, mStb_q;

    // ==========================================================
    // Bus decode
    wire inSync = (mode_q == UAMC_SYNC);
    wire wrFire = awvalid & awready & wvalid & wready;
    wire rdFire = arvalid & arready;
    wire selCtrl = (awaddr == `UAMC_OFS_CTRL);
    wire selMask = (awaddr == `UAMC_OFS_MASK);
    wire selMeas = (awaddr == `UAMC_OFS_MEAS);
    wire selHset = (awaddr == `UAMC_OFS_HSET);
    wire wrMapped = selCtrl | selMask | selMeas | selHset;
    // Outside synchronous mode register writes are refused with an error response
    wire wrOk = wrFire & wrMapped & inSync;
    wire wrCtrl = wrOk & selCtrl & wstrb[0] & wstrb[1];
    wire wrMask = wrOk & selMask & wstrb[0];
    wire wrMeas = wrOk & selMeas & wstrb[0];
    wire wrHset = wrOk & selHset & wstrb[0] & wdata[0];
    wire accReq = wrCtrl & wdata[`UAMC_CTRL_ACC];
    wire [31:0] rdWord =
        (araddr == `UAMC_OFS_CTRL) ? 32'(ctrl_q) :
        (araddr == `UAMC_OFS_MASK) ? 32'(mask_q) :
        (araddr == `UAMC_OFS_MEAS) ?
            32'({measCode_q, 6'h00, measNotify_q, measStart_q}) :
        (araddr == `UAMC_OFS_STAT) ? 32'({idFellAlt_q, altPend_q, mode_q}) :
        32'h0000_0000;
    wire rdMapped = (araddr == `UAMC_OFS_CTRL) | (araddr == `UAMC_OFS_MASK) |
        (araddr == `UAMC_OFS_MEAS) | (araddr == `UAMC_OFS_STAT) |
        (araddr == `UAMC_OFS_HSET);

    // ==========================================================
    // Mode and event decode
    wire txRoute = ctrl_q[`UAMC_CTRL_TXEN];
    wire rxRoute = ctrl_q[`UAMC_CTRL_RXEN];
    wire inAcc = (mode_q == UAMC_ACC);
    wire inHset = (mode_q == UAMC_HSET);
    wire uartOn = inAcc & (txRoute | rxRoute);
    // Compare live levels with the pre-DIR snapshot
    wire irqHit = |((irqSrc ^ snap_q) & mask_q);
    wire idFell = idPrev_q & ~idGroundedComparator;
    wire altSet = measDone & measStart_q & measNotify_q;
    wire rxSend = inSync & (idFell | altPend_q);
    wire hsBusVld = busPowerValidComparator & mask_q[BUSVLD_IRQ];

    // ==========================================================
    // Next mode
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            UAMC_SYNC:
            begin
                if (accReq | wrHset)
                begin
                    mode_d = UAMC_ENTER;
                end
            end
            UAMC_ENTER:
            begin
                // Snapshot taken here, DIR rises on leaving
                mode_d = hsetTarget_q ? UAMC_HSET : UAMC_ACC;
            end
            UAMC_ACC, UAMC_HSET:
            begin
                if (stp)
                begin
                    mode_d = UAMC_EXIT;
                end
            end
            UAMC_EXIT:
            begin
                if (!stp)
                begin
                    mode_d = UAMC_SYNC;
                end
            end
        endcase
    end

    // ==========================================================
    // Mode register; the pin reset forces synchronous mode on the next enabled edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= UAMC_SYNC;
            hsetTarget_q <= 1'b0;
            snap_q <= '0;
        end
        else if (ce)
        begin
            mode_q <= hardResetPinN ? mode_d : UAMC_SYNC;
            hsetTarget_q <= inSync ? wrHset : hsetTarget_q;
            snap_q <= (mode_q == UAMC_ENTER) ? irqSrc : snap_q;
        end
    end

    // ==========================================================
    // Software-visible registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `UAMC_CTRL_RST;
            mask_q <= '0;
            measStart_q <= 1'b0;
            measNotify_q <= 1'b0;
            measCode_q <= '0;
        end
        else if (ce)
        begin
            if (!hardResetPinN)
            begin
                ctrl_q <= `UAMC_CTRL_RST;
            end
            else if (wrCtrl)
            begin
                ctrl_q <= wdata[`UAMC_CTRL_W-1:0];
            end
            else if (mode_q == UAMC_EXIT)
            begin
                ctrl_q[`UAMC_CTRL_ACC] <= 1'b0;
            end
            if (wrMask)
            begin
                mask_q <= wdata[IRQ_W-1:0];
            end
            // Completion clears the start bit so it can be polled
            if (measDone & measStart_q)
            begin
                measStart_q <= 1'b0;
                measCode_q <= measCode;
            end
            else if (wrMeas)
            begin
                measStart_q <= wdata[`UAMC_MEAS_START];
            end
            if (wrMeas)
            begin
                measNotify_q <= wdata[`UAMC_MEAS_NOTIFY];
            end
        end
    end

    // ==========================================================
    // Event flags; a set in the clearing cycle wins
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            altPend_q <= 1'b0;
            idFellAlt_q <= 1'b0;
            idPrev_q <= 1'b1;
            rxStb_q <= 1'b0;
            rxByte_q <= 8'h00;
            mStb_q <= 1'b0;
        end
        else if (ce)
        begin
            idPrev_q <= idGroundedComparator;
            altPend_q <= altSet | (altPend_q & ~rxSend);
            idFellAlt_q <= (idFell & ~inSync) | (idFellAlt_q & ~inSync);
            rxStb_q <= rxSend;
            // Line state only travels in synchronous mode
            rxByte_q <= rxSend ? {altPend_q, idGroundedComparator, 4'h0, lineState}
                : rxByte_q;
            mStb_q <= wrMeas & wdata[`UAMC_MEAS_START] & ~measStart_q;
        end
    end

    // ==========================================================
    // Data bus redefinition per mode
    logic [7:0] busOut, busOe;
    always_comb
    begin
        busOut = 8'h00;
        busOe = 8'h00;
        if (mode_d == UAMC_ACC)
        begin
            busOe = 8'hFE;
            busOut[1] = rxRoute & dpIn;
            busOut[3] = irqHit | idFellAlt_q | (idFell & ~inSync);
        end
        else if (mode_d == UAMC_HSET)
        begin
            busOe = 8'h3B;
            busOut[0] = sessionValidComparator;
            busOut[1] = hsBusVld;
            busOut[4] = idGroundedComparator;
            busOut[5] = idFloatingState;
        end
    end

    // ==========================================================
    // Pin-side registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dOut_q <= 8'h00;
            dOe_q <= 8'h00;
            dir_q <= 1'b0;
            clk_q <= 1'b1;
            dm_q <= 1'b0;
            dmOe_q <= 1'b0;
            pu_q <= 1'b0;
            regSel_q <= 1'b0;
            regLv_q <= 2'h0;
            ls_q <= 1'b0;
            left_q <= 1'b0;
            right_q <= 1'b0;
            gnd_q <= 1'b0;
            wpu_q <= 1'b0;
            spu_q <= 1'b0;
        end
        else if (ce)
        begin
            dOut_q <= busOut;
            dOe_q <= busOe;
            dir_q <= (mode_d == UAMC_ACC) | (mode_d == UAMC_HSET);
            clk_q <= ~(inAcc | inHset) | ctrl_q[`UAMC_CTRL_KEEP];
            dm_q <= inAcc & txRoute & dataIn[0];
            dmOe_q <= inAcc & txRoute;
            pu_q <= uartOn;
            regSel_q <= uartOn;
            regLv_q <= uartOn ? ctrl_q[`UAMC_CTRL_REGLV +: 2] : 2'h0;
            ls_q <= uartOn & (ctrl_q[`UAMC_CTRL_XCVR +: 2] == `UAMC_XCVR_LS);
            left_q <= ctrl_q[`UAMC_CTRL_LEFT];
            right_q <= ctrl_q[`UAMC_CTRL_RIGHT];
            gnd_q <= inHset & dataIn[2];
            wpu_q <= inHset & dataIn[6];
            spu_q <= inHset & dataIn[7];
        end
    end

    // ==========================================================
    // AXI4-Lite handshakes: write ready one cycle after both valids, read ready one cycle after ARVALID
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            awr_q <= 1'b0;
            wr_q <= 1'b0;
            bv_q <= 1'b0;
            bresp_q <= `UAMC_RESP_OK;
            arr_q <= 1'b0;
            rv_q <= 1'b0;
            rresp_q <= `UAMC_RESP_OK;
            rdata_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            awr_q <= awvalid & wvalid & ~awr_q & ~bv_q;
            wr_q <= awvalid & wvalid & ~awr_q & ~bv_q;
            if (wrFire)
            begin
                bv_q <= 1'b1;
                bresp_q <= wrOk ? `UAMC_RESP_OK : `UAMC_RESP_ERR;
            end
            else if (bready)
            begin
                bv_q <= 1'b0;
            end
            arr_q <= arvalid & ~arr_q & ~rv_q;
            if (rdFire)
            begin
                rv_q <= 1'b1;
                rdata_q <= rdWord;
                rresp_q <= rdMapped ? `UAMC_RESP_OK : `UAMC_RESP_ERR;
            end
            else if (rready)
            begin
                rv_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Output wiring
    assign awready = awr_q;
    assign wready = wr_q;
    assign bvalid = bv_q;
    assign bresp = bresp_q;
    assign arready = arr_q;
    assign rvalid = rv_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign dir = dir_q;
    assign dataOut = dOut_q;
    assign dataOe = dOe_q;
    assign clkRun = clk_q;
    assign rxcmdStrobe = rxStb_q;
    assign rxcmdByte = rxByte_q;
    assign dmOut = dm_q;
    assign dmOe = dmOe_q;
    assign uartPullupEn = pu_q;
    assign uartRegulatorSel = regSel_q;
    assign regulatorLevel = regLv_q;
    assign lowSpeedEdges = ls_q;
    assign leftAudioSwitch = left_q;
    assign rightAudioSwitch = right_q;
    assign idGroundDrive = gnd_q;
    assign idWeakPullupEnable = wpu_q;
    assign idStrongPullupEnable = spu_q;
    assign measStartPulse = mStb_q;

    // ==========================================================
    // Assertions
    sequence accEntry;
        ce && inSync && accReq && hardResetPinN ##1 ce && hardResetPinN && mode_q == UAMC_ENTER;
    endsequence

    sequence exitSeen;
        ce && (inAcc || inHset) && stp && hardResetPinN;
    endsequence

    dir_rise_a: assert property (@(posedge core_clk) disable iff (rst)
        accEntry |=> dir && inAcc)
        else $error("DIR did not rise two cycles after accessory request");

    dir_drop_a: assert property (@(posedge core_clk) disable iff (rst)
        exitSeen |=> !dir && mode_q == UAMC_EXIT)
        else $error("DIR did not drop after STP in alternate mode");

    clk_stop_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && inAcc && !ctrl_q[`UAMC_CTRL_KEEP] |=> !clkRun)
        else $error("Interface clock runs in accessory mode");

    acc_select_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && mode_q == UAMC_EXIT && !wrCtrl && hardResetPinN
        |=> !ctrl_q[`UAMC_CTRL_ACC])
        else $error("Accessory select not cleared on exit");

    irq_pin_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && inAcc && !stp && irqHit |=> dataOut[3] && dataOe[3])
        else $error("Interrupt not shown on DATA3");

    acc_low_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && inAcc && !stp && hardResetPinN |=> dataOut[2] == 1'b0 && dataOut[7:4] == 4'h0)
        else $error("Reserved data lines not low");

    ref_write_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && wrFire && !inSync |=> bresp == `UAMC_RESP_ERR && $stable(mask_q))
        else $error("Register write accepted outside synchronous mode");

    meas_done_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && measDone && measStart_q |=> !measStart_q && measCode_q == $past(measCode))
        else $error("Measurement completion not recorded");

    id_rxcmd_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && inSync && idFell |=> rxcmdStrobe && !rxcmdByte[`UAMC_RXCMD_ID])
        else $error("ID fall RXCMD missing");

    hs_float_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && inHset && !stp && hardResetPinN |=> dataOut[5] == $past(idFloatingState))
        else $error("Floating state not on DATA5");

endmodule

// *** tb/uamc_link_model.sv ***
/*
 * Link controller model: resolves the shared data bus and runs the exit handshake.
 * Assumes the device drives a bus bit only where its output enable is high.
 */
`timescale 1ns/1ps
module uamc_link_model
(
    // Clock
    input wire logic core_clk,
    // Device side
    input wire logic dir,
    input wire logic [7:0] dataOut,
    input wire logic [7:0] dataOe,
    // Link side
    input wire logic [7:0] linkBus,
    output logic stp,
    output logic [7:0] dataIn
);
    // ==========================================
    // Bus level: device where enabled, else the link's drive
    assign dataIn = (dataOe & dataOut) | (~dataOe & linkBus);
    // Stop idles low once the link is configured
    initial stp = 1'b0;

    // ==========================================
    // Exit: raise stop, wait for the turnaround, hold, then release
    task automatic leave(input int hold);
        int i;
        begin
            i = 0;
            @(posedge core_clk);
            stp <= 1'b1;
            // Bounded so a device that never turns round cannot hang the run
            do @(posedge core_clk); while (dir === 1'b1 && ++i < 40);
            // A slow link keeps stop up after the turnaround
            repeat (hold) @(posedge core_clk);
            stp <= 1'b0;
            @(posedge core_clk);
        end
    endtask
endmodule

// *** tb/tb_ulpi_alternate_mode_control.sv ***
/*
 * Self-checking bench of the alternate-mode controller.
 * Assumes the shared header, the package and the link model are compiled first.
 */
`timescale 1ns/1ps
`include "uamc_cfg.svh"
module tb_ulpi_alternate_mode_control import uamc_pkg::*;;
    // ==========================================
    // Stimulus, all given a value at time zero
    logic core_clk = 1'b0, rst = 1'b1, hardResetPinN = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, linkBus = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [4:0] irqSrc = 5'h00;
    logic sess = 1'b0, busv = 1'b0, id_grounded_comparator = 1'b1, idFlt = 1'b0, dpIn = 1'b0, measDone = 1'b0;
    logic [1:0] lineState = 2'h0;
    logic [2:0] measCode = 3'h0;
    // Observed outputs
    wire awready, wready, bvalid, arready, rvalid, dir, stp, clkRun, rxcmdStrobe, dmOut, dmOe;
    wire uartPullupEn, uartRegulatorSel, lowSpeedEdges, leftAudioSwitch, rightAudioSwitch;
    wire measStartPulse;
    wire idGroundDrive, idWeakPullupEnable, idStrongPullupEnable;
    wire [1:0] bresp, rresp, regulatorLevel;
    wire [31:0] rdata;
    wire [7:0] dataIn, dataOut, dataOe, rxcmdByte;
    // Expected bus answers, oldest first
    logic [33:0] expQ [$];
    int n_mismatch = 0;
    int check_count = 0;
    integer seed = 32'haa761db8;
    logic [31:0] d1, rnd;
    // Signals that waits can select by index
    wire [6:0] sigs = {rxcmdStrobe, measStartPulse, dir, rvalid, arready, bvalid, awready & wready};

    // ==========================================
    // Clock, 20 ns period
    always #10 core_clk = ~core_clk;

    uamc_alt_mode uamc_alt_mode_inst
    (
        .core_clk(core_clk), .rst(rst), .ce(1'b1), .hardResetPinN(hardResetPinN),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .stp(stp), .dir(dir), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .clkRun(clkRun), .lineState(lineState),
        .rxcmdStrobe(rxcmdStrobe), .rxcmdByte(rxcmdByte), .irqSrc(irqSrc),
        .sessionValidComparator(sess), .busPowerValidComparator(busv),
        .idGroundedComparator(id_grounded_comparator), .idFloatingState(idFlt), .dpIn(dpIn), .dmOut(dmOut),
        .dmOe(dmOe), .uartPullupEn(uartPullupEn), .uartRegulatorSel(uartRegulatorSel),
        .regulatorLevel(regulatorLevel), .lowSpeedEdges(lowSpeedEdges),
        .leftAudioSwitch(leftAudioSwitch), .rightAudioSwitch(rightAudioSwitch),
        .idGroundDrive(idGroundDrive), .idWeakPullupEnable(idWeakPullupEnable),
        .idStrongPullupEnable(idStrongPullupEnable), .measStartPulse(measStartPulse),
        .measDone(measDone), .measCode(measCode)
    );

    uamc_link_model uamc_link_model_inst
    (
        .core_clk(core_clk), .dir(dir), .dataOut(dataOut), .dataOe(dataOe),
        .linkBus(linkBus), .stp(stp), .dataIn(dataIn)
    );

    // ==========================================
    // Compare, report and close
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        begin
            check_count++;
            if (s !== e)
            begin
                n_mismatch++;
                $display("[FAIL] %0t: seen %0h, expected %0h", $time, s, e);
            end
        end
    endtask

    task automatic print_verdict;
        begin
            $display("checks %0d, mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Bounded wait on one selected signal; running out closes the run
    task automatic waitSig(input int k);
        int j;
        begin
            j = 0;
            do @(posedge core_clk); while (sigs[k] !== 1'b1 && ++j < 40);
            if (sigs[k] !== 1'b1)
            begin
                n_mismatch++;
                print_verdict();
            end
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        begin
            expQ.push_back({r, 32'h0});
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            waitSig(0);
            awvalid <= 1'b0;
            wvalid <= 1'b0;
            waitSig(1);
        end
    endtask

    // Read: the answer is noted now and judged by the monitor
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        begin
            expQ.push_back({r, d});
            araddr <= a;
            arvalid <= 1'b1;
            waitSig(2);
            arvalid <= 1'b0;
            waitSig(3);
        end
    endtask

    // ==========================================
    // Monitor: each bus answer takes the oldest note; no status bytes while turned round
    always @(posedge core_clk)
    begin
        if (bvalid === 1'b1 || rvalid === 1'b1)
            chk(bvalid === 1'b1 ? {bresp, 32'h0} : {rresp, rdata}, expQ.pop_front());
        if (dir === 1'b1)
            chk(rxcmdStrobe, 1'b0);
    end

    // Watchdog against a hang
    initial
    begin
        tick(5000);
        n_mismatch++;
        print_verdict();
    end

    // ==========================================
    // Main sequence
    initial
    begin
        tick(10);
        rst <= 1'b0;
        // Answers are always accepted at once
        bready <= 1'b1;
        rready <= 1'b1;
        tick(1);
        chk(clkRun, 1'b1);
        axr(`UAMC_OFS_CTRL, `UAMC_CTRL_RST, `UAMC_RESP_OK);
        axr(8'h14, 32'h0, `UAMC_RESP_ERR);
        axw(8'h14, 32'h0, `UAMC_RESP_ERR);
        axw(`UAMC_OFS_MASK, 32'h1F, `UAMC_RESP_OK);
        // Audio switches follow their enables straight after the write
        axw(`UAMC_OFS_CTRL, 32'h070, `UAMC_RESP_OK);
        tick(2);
        chk({leftAudioSwitch, rightAudioSwitch}, 2'b11);
        axw(`UAMC_OFS_CTRL, 32'h050, `UAMC_RESP_OK);
        tick(2);
        chk({leftAudioSwitch, rightAudioSwitch}, 2'b10);
        // Grounded ID in synchronous mode gives a status byte
        lineState <= 2'h2;
        id_grounded_comparator <= 1'b0;
        waitSig(6);
        chk({rxcmdByte[6], rxcmdByte[1:0]}, 3'b010);
        id_grounded_comparator <= 1'b1;
        // Measurement with completion notice
        axw(`UAMC_OFS_MEAS, 32'h3, `UAMC_RESP_OK);
        // The start pulse stands only in the cycle that the response appears
        chk(measStartPulse, 1'b1);
        rnd = $random(seed);
        measCode <= rnd[2:0];
        tick(2);
        measDone <= 1'b1;
        tick(1);
        measDone <= 1'b0;
        waitSig(6);
        chk(rxcmdByte[7], 1'b1);
        axr(`UAMC_OFS_MEAS, {21'h0, rnd[2:0], 8'h02}, `UAMC_RESP_OK);
        // UART: routes and speed first, then accessory select
        rnd = $random(seed);
        d1 = {22'h0, rnd[1:0], 8'h86};
        axw(`UAMC_OFS_CTRL, d1, `UAMC_RESP_OK);
        axw(`UAMC_OFS_CTRL, d1 | 32'h8, `UAMC_RESP_OK);
        waitSig(4);
        tick(2);
        chk({clkRun, dataOe, dmOe, uartPullupEn}, {1'b0, 8'hFE, 2'b11});
        chk({uartRegulatorSel, regulatorLevel, lowSpeedEdges}, {1'b1, rnd[1:0], 1'b1});
        chk({dataOut[7:4], dataOut[3:2]}, 6'h0);
        linkBus <= {7'h0, rnd[4]};
        dpIn <= rnd[5];
        lineState <= rnd[7:6];
        tick(3);
        chk({dmOut, dataOut[1]}, {rnd[4], rnd[5]});
        irqSrc <= irqSrc ^ (rnd[12:8] | 5'h01);
        tick(3);
        chk(dataOut[3], 1'b1);
        axw(`UAMC_OFS_CTRL, 32'h0, `UAMC_RESP_ERR);
        axr(`UAMC_OFS_CTRL, d1 | 32'h8, `UAMC_RESP_OK);
        uamc_link_model_inst.leave(0);
        chk(dir, 1'b0);
        tick(1);
        axr(`UAMC_OFS_CTRL, d1, `UAMC_RESP_OK);
        chk(clkRun, 1'b1);
        // Keep-running bit holds the interface clock; slow link on exit
        axw(`UAMC_OFS_CTRL, d1 | 32'h9, `UAMC_RESP_OK);
        waitSig(4);
        tick(2);
        chk(clkRun, 1'b1);
        uamc_link_model_inst.leave(5);
        chk(dir, 1'b0);
        // Headset mode with a pull-up on so the floating flag means something
        axw(`UAMC_OFS_HSET, 32'h1, `UAMC_RESP_OK);
        waitSig(4);
        rnd = $random(seed);
        {sess, busv, id_grounded_comparator, idFlt} <= rnd[3:0];
        linkBus <= rnd[11:4] | 8'h40;
        tick(3);
        chk(dataOe, 8'h3B);
        chk(dataOut & 8'h3B, {2'b00, rnd[0], rnd[1], 2'b00, rnd[2], rnd[3]});
        chk({idGroundDrive, idWeakPullupEnable, idStrongPullupEnable}, {rnd[6], 1'b1, rnd[11]});
        id_grounded_comparator <= 1'b1;
        linkBus <= 8'h00;
        uamc_link_model_inst.leave(2);
        chk(dir, 1'b0);
        // Hard reset pin pulls the device out of accessory mode
        axw(`UAMC_OFS_CTRL, 32'h048, `UAMC_RESP_OK);
        waitSig(4);
        // Grounded ID outside synchronous mode shows as the interrupt line
        chk(dataOut[3], 1'b0);
        id_grounded_comparator <= 1'b0;
        tick(3);
        chk(dataOut[3], 1'b1);
        hardResetPinN <= 1'b0;
        tick(1);
        hardResetPinN <= 1'b1;
        tick(3);
        chk(dir, 1'b0);
        axr(`UAMC_OFS_CTRL, `UAMC_CTRL_RST, `UAMC_RESP_OK);
        print_verdict();
    end
endmodule
